// ===== hw/scss_bitclk.sv
module scss_bitclk
  import scss_pkg::*;
#(
  parameter int unsigned CLK_HZ = scss_pkg::SCS_CLK_HZ
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] rate_code,
  output logic            bit_tick
);

  logic [SCS_DIV_W-1:0] cnt_ff;
  logic [SCS_DIV_W-1:0] nxt_cnt;
  logic [SCS_DIV_W-1:0] reload;

  // Cycles per bit less one, rounded down, never below one cycle
  function automatic logic [SCS_DIV_W-1:0] div_of(input int unsigned bps);
    int unsigned n;
    n = CLK_HZ / bps;
    if (n < 1) begin
      n = 1;
    end
    return SCS_DIV_W'(n - 1);
  endfunction

  always_comb begin
    case (rate_code)
      3'h0:    reload = div_of(SCS_BPS_0);
      3'h1:    reload = div_of(SCS_BPS_1);
      3'h2:    reload = div_of(SCS_BPS_2);
      3'h3:    reload = div_of(SCS_BPS_3);
      3'h4:    reload = div_of(SCS_BPS_4);
      default: reload = div_of(SCS_BPS_5);
    endcase
  end

  // Rate change takes hold at the next wrap, not mid bit
  always_comb begin
    if (cnt_ff == '0) begin
      nxt_cnt = reload;
    end else begin
      nxt_cnt = cnt_ff - SCS_DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign bit_tick = (cnt_ff == '0);

endmodule // scss_bitclk

// ===== hw/scss_pkg.sv
package scss_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] SCS_REG_STATION = 4'h0;
  localparam logic [3:0] SCS_REG_PROTO   = 4'h1;
  localparam logic [3:0] SCS_REG_RATE    = 4'h2;
  localparam logic [3:0] SCS_REG_SOURCE  = 4'h3;
  localparam logic [3:0] SCS_REG_CWORD   = 4'h4;
  localparam logic [3:0] SCS_REG_STATUS  = 4'h5;

  // Protocol codes
  localparam logic [1:0] SCS_PROTO_NATIVE = 2'h0;
  localparam logic [1:0] SCS_PROTO_BLDG   = 2'h1;
  localparam logic [1:0] SCS_PROTO_RTU    = 2'h3;

  // Station address limits
  localparam logic [7:0] SCS_ADDR_NATIVE_MIN = 8'h00;
  localparam logic [7:0] SCS_ADDR_NATIVE_MAX = 8'hF7;
  localparam logic [7:0] SCS_ADDR_BLDG_MIN   = 8'h01;
  localparam logic [7:0] SCS_ADDR_BLDG_MAX   = 8'hFF;
  localparam logic [7:0] SCS_ADDR_RTU_MIN    = 8'h01;
  localparam logic [7:0] SCS_ADDR_RTU_MAX    = 8'hF7;

  // Reset values
  localparam logic [7:0] SCS_RST_STATION = 8'h01;
  localparam logic [1:0] SCS_RST_PROTO   = 2'h0;
  localparam logic [2:0] SCS_RST_RATE    = 3'h5;
  localparam logic [1:0] SCS_RST_SOURCE  = 2'h3;
  localparam logic [15:0] SCS_RST_CWORD  = 16'hFFFF;

  // Bit rate codes and their bits per second
  localparam logic [2:0] SCS_RATE_MAX_CODE = 3'h5;
  localparam int unsigned SCS_BPS_0 = 300;
  localparam int unsigned SCS_BPS_1 = 600;
  localparam int unsigned SCS_BPS_2 = 1200;
  localparam int unsigned SCS_BPS_3 = 2400;
  localparam int unsigned SCS_BPS_4 = 4800;
  localparam int unsigned SCS_BPS_5 = 9600;

  // Clock rate
  localparam int unsigned SCS_CLK_HZ = 250000000;
  localparam int unsigned SCS_DIV_W  = 20;

  // Control word bit positions
  localparam int unsigned SCS_CW_DCBRAKE = 2;
  localparam int unsigned SCS_CW_COAST   = 3;
  localparam int unsigned SCS_CW_QSTOP   = 4;
  localparam int unsigned SCS_CW_VALID   = 10;

  // Source selector field positions
  localparam int unsigned SCS_SRC_COAST_LSB   = 0;
  localparam int unsigned SCS_SRC_QSTOP_LSB   = 2;
  localparam int unsigned SCS_SRC_DCBRAKE_LSB = 4;

  // Command source modes
  typedef enum logic [1:0] {
    SCS_SRC_DIGITAL = 2'b00,
    SCS_SRC_SERIAL  = 2'b01,
    SCS_SRC_AND     = 2'b10,
    SCS_SRC_OR      = 2'b11
  } scss_src_t;

endpackage

// ===== hw/scss_top.sv
module scss_top
  import scss_pkg::*;
#(
  parameter int unsigned CLK_HZ = scss_pkg::SCS_CLK_HZ
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic        REG_LOCAL,
  output logic      [15:0] REG_RDATA,
  input  wire logic [15:0] SER_CWORD,
  input  wire logic        SER_CWORD_STB,
  input  wire logic        DI_COAST_N,
  input  wire logic        DI_QSTOP_N,
  input  wire logic        DI_DCBRAKE_N,
  output logic             COAST_REQ,
  output logic             QSTOP_REQ,
  output logic             DCBRAKE_REQ,
  output logic             BIT_TICK,
  output logic      [7:0]  STATION_ADDR,
  output logic      [2:0]  RATE_CODE
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  station_ff;
  logic [1:0]  proto_ff;
  logic [2:0]  rate_ff;
  logic [5:0]  source_ff;
  logic [15:0] cword_ff;
  logic        refused_ff;
  logic        coast_ff;
  logic        qstop_ff;
  logic        dcbrake_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        wr_station;
  logic        wr_proto;
  logic        wr_rate;
  logic        wr_source;
  logic        addr_ok;
  logic        proto_ok;
  logic        refuse_now;
  logic        rd_status;
  logic        station_data_ok;
  logic        rate_data_ok;
  logic [7:0]  nxt_station;
  logic [1:0]  nxt_proto;
  logic [2:0]  nxt_rate;
  logic [5:0]  nxt_source;
  logic        nxt_refused;
  logic [15:0] nxt_cword;
  logic        nxt_coast;
  logic        nxt_qstop;
  logic        nxt_dcbrake;

  // True when the address fits the range of the given protocol
  function automatic logic addr_in_range(input logic [1:0] proto,
                                         input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    case (proto)
      SCS_PROTO_NATIVE: ok = (a >= SCS_ADDR_NATIVE_MIN) &&
                             (a <= SCS_ADDR_NATIVE_MAX);
      SCS_PROTO_BLDG:   ok = (a >= SCS_ADDR_BLDG_MIN) &&
                             (a <= SCS_ADDR_BLDG_MAX);
      SCS_PROTO_RTU:    ok = (a >= SCS_ADDR_RTU_MIN) &&
                             (a <= SCS_ADDR_RTU_MAX);
      default:          ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Run level of one command; both sources are active low
  function automatic logic run_level(input logic [1:0] src,
                                     input logic di, input logic ser);
    logic run;
    run = 1'b0;
    case (scss_src_t'(src))
      SCS_SRC_DIGITAL: run = di;
      SCS_SRC_SERIAL:  run = ser;
      SCS_SRC_AND:     run = di | ser;
      SCS_SRC_OR:      run = di & ser;
      default:         run = 1'b0;
    endcase
    return run;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode; station, protocol and rate only from the local unit
  assign wr_station = REG_WR && (REG_ADDR == SCS_REG_STATION) && REG_LOCAL;
  assign wr_proto   = REG_WR && (REG_ADDR == SCS_REG_PROTO) && REG_LOCAL;
  assign wr_rate    = REG_WR && (REG_ADDR == SCS_REG_RATE) && REG_LOCAL;
  assign wr_source  = REG_WR && (REG_ADDR == SCS_REG_SOURCE);
  assign addr_ok    = addr_in_range(proto_ff, REG_WDATA[7:0]);
  assign proto_ok   = addr_in_range(REG_WDATA[1:0], station_ff) &&
                      (REG_WDATA[15:2] == '0);
  assign refuse_now = REG_WR && !REG_LOCAL &&
                      ((REG_ADDR == SCS_REG_STATION) ||
                       (REG_ADDR == SCS_REG_PROTO) ||
                       (REG_ADDR == SCS_REG_RATE));

  // Bad values are dropped whole, never clipped into range
  assign station_data_ok = addr_ok && (REG_WDATA[15:8] == '0);

  always_comb begin
    nxt_station = station_ff;
    if (wr_station && station_data_ok) begin
      nxt_station = REG_WDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      station_ff <= SCS_RST_STATION;
    end else begin
      station_ff <= nxt_station;
    end
  end

  // Protocol change refused if current address would fall out of range
  always_comb begin
    nxt_proto = proto_ff;
    if (wr_proto && proto_ok) begin
      nxt_proto = REG_WDATA[1:0];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      proto_ff <= SCS_RST_PROTO;
    end else begin
      proto_ff <= nxt_proto;
    end
  end

  assign rate_data_ok = (REG_WDATA[15:3] == '0) &&
                        (REG_WDATA[2:0] <= SCS_RATE_MAX_CODE);

  always_comb begin
    nxt_rate = rate_ff;
    if (wr_rate && rate_data_ok) begin
      nxt_rate = REG_WDATA[2:0];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rate_ff <= SCS_RST_RATE;
    end else begin
      rate_ff <= nxt_rate;
    end
  end

  // Either side may pick the command sources
  always_comb begin
    nxt_source = source_ff;
    if (wr_source) begin
      nxt_source = REG_WDATA[5:0];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      source_ff <= {SCS_RST_SOURCE, SCS_RST_SOURCE, SCS_RST_SOURCE};
    end else begin
      source_ff <= nxt_source;
    end
  end

  // Sticky refusal flag; a new refusal wins over the clear
  assign rd_status = REG_RD && (REG_ADDR == SCS_REG_STATUS);

  always_comb begin
    nxt_refused = refused_ff;
    if (refuse_now) begin
      nxt_refused = 1'b1;
    end else if (rd_status) begin
      nxt_refused = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= nxt_refused;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only words marked valid replace the held control word
  always_comb begin
    nxt_cword = cword_ff;
    if (SER_CWORD_STB && SER_CWORD[SCS_CW_VALID]) begin
      nxt_cword = SER_CWORD;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cword_ff <= SCS_RST_CWORD;
    end else begin
      cword_ff <= nxt_cword;
    end
  end

  // Registered so the drive never sees a mode-switch glitch
  always_comb begin
    nxt_coast   = !run_level(source_ff[SCS_SRC_COAST_LSB +: 2],
                             DI_COAST_N,
                             cword_ff[SCS_CW_COAST]);
    nxt_qstop   = !run_level(source_ff[SCS_SRC_QSTOP_LSB +: 2],
                             DI_QSTOP_N,
                             cword_ff[SCS_CW_QSTOP]);
    nxt_dcbrake = !run_level(source_ff[SCS_SRC_DCBRAKE_LSB +: 2],
                             DI_DCBRAKE_N,
                             cword_ff[SCS_CW_DCBRAKE]);
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      coast_ff <= 1'b0;
    end else begin
      coast_ff <= nxt_coast;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      qstop_ff <= 1'b0;
    end else begin
      qstop_ff <= nxt_qstop;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      dcbrake_ff <= 1'b0;
    end else begin
      dcbrake_ff <= nxt_dcbrake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped indices read zero
  always_comb begin
    nxt_rdata = '0;
    case (REG_ADDR)
      SCS_REG_STATION: nxt_rdata = {8'h00, station_ff};
      SCS_REG_PROTO:   nxt_rdata = {14'h0000, proto_ff};
      SCS_REG_RATE:    nxt_rdata = {13'h0000, rate_ff};
      SCS_REG_SOURCE:  nxt_rdata = {10'h000, source_ff};
      SCS_REG_CWORD:   nxt_rdata = cword_ff;
      SCS_REG_STATUS:  nxt_rdata = {12'h000, refused_ff, dcbrake_ff,
                                    qstop_ff, coast_ff};
      default:         nxt_rdata = '0;
    endcase
  end

  // Data stand in each cycle after one with REG_RD high, zero otherwise
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= '0;
    end else if (REG_RD) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  scss_bitclk #(
    .CLK_HZ (CLK_HZ)
  ) u_bitclk (
    .clk       (MCLK),
    .rst_n     (RESETN),
    .rate_code (rate_ff),
    .bit_tick  (BIT_TICK)
  );

  assign REG_RDATA    = rdata_ff;
  assign COAST_REQ    = coast_ff;
  assign QSTOP_REQ    = qstop_ff;
  assign DCBRAKE_REQ  = dcbrake_ff;
  assign STATION_ADDR = station_ff;
  // Exposed so the link master can be set to the same rate
  assign RATE_CODE    = rate_ff;

endmodule // scss_top

// ===== tb/scss_far.sv
module scss_far
  import scss_pkg::*;
(
  input  wire logic        mclk,
  output logic      [15:0] ser_cword,
  output logic             ser_cword_stb,
  output logic             di_coast_n,
  output logic             di_qstop_n,
  output logic             di_dcbrake_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ser_cword = 16'h0000;
    ser_cword_stb = 1'b0;
    {di_dcbrake_n, di_qstop_n, di_coast_n} = 3'h7;
  end
  // Released word shows its inverse, never a stale copy
  task automatic send(input logic [15:0] w);
    @(posedge mclk);
    ser_cword <= w;
    ser_cword_stb <= 1'b1;
    @(posedge mclk);
    ser_cword <= ~w;
    ser_cword_stb <= 1'b0;
  endtask
  // Terminals active low, 0 asks for the function
  task automatic set_di(input logic [2:0] lv);
    @(posedge mclk);
    {di_dcbrake_n, di_qstop_n, di_coast_n} <= lv;
  endtask
endmodule // scss_far

// ===== tb/scss_top_bench.sv
module scss_top_bench
  import scss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HZ = 96000;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        loc = 1'b1;
  logic [15:0] rdata;
  logic [15:0] cword;
  logic        cstb;
  wire [2:0]   di_n;
  wire [2:0]   reqs;
  logic        tick;
  logic [7:0]  station;
  logic [2:0]  rate;
  logic        run;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          per;
  int unsigned bps[6] = '{SCS_BPS_0, SCS_BPS_1, SCS_BPS_2, SCS_BPS_3,
                          SCS_BPS_4, SCS_BPS_5};
  int unsigned cwb[3] = '{SCS_CW_COAST, SCS_CW_QSTOP, SCS_CW_DCBRAKE};
  int unsigned sl[3]  = '{SCS_SRC_COAST_LSB, SCS_SRC_QSTOP_LSB,
                          SCS_SRC_DCBRAKE_LSB};
  scss_top #(.CLK_HZ(HZ)) u_scss_top (
    .MCLK(mclk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_LOCAL(loc), .REG_RDATA(rdata),
    .SER_CWORD(cword), .SER_CWORD_STB(cstb), .DI_COAST_N(di_n[0]),
    .DI_QSTOP_N(di_n[1]), .DI_DCBRAKE_N(di_n[2]), .COAST_REQ(reqs[0]),
    .QSTOP_REQ(reqs[1]), .DCBRAKE_REQ(reqs[2]), .BIT_TICK(tick),
    .STATION_ADDR(station), .RATE_CODE(rate));
  scss_far u_scss_far (
    .mclk(mclk), .ser_cword(cword), .ser_cword_stb(cstb),
    .di_coast_n(di_n[0]), .di_qstop_n(di_n[1]), .di_dcbrake_n(di_n[2]));
  //////////////////////////////////////////////////////////////////////
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [15:0] g,
                     input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic l);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    loc <= l;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input string n);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask
  task automatic ws(input logic [15:0] d, input logic [7:0] e);
    wr(SCS_REG_STATION, d, 1'b1);
    rd(SCS_REG_STATION, {8'h00, e}, "station");
    chk("station_pin", 16'(station), {8'h00, e});
  endtask
  task automatic wp(input logic [15:0] d, input logic [15:0] e);
    wr(SCS_REG_PROTO, d, 1'b1);
    rd(SCS_REG_PROTO, e, "proto");
  endtask
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 1000);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd(SCS_REG_STATION, 16'h0001, "station");
    rd(SCS_REG_RATE, 16'h0005, "rate");
    rd(SCS_REG_SOURCE, 16'h003F, "source");
    wr(SCS_REG_STATION, 16'h0010, 1'b0);
    rd(SCS_REG_STATION, 16'h0001, "station");
    rd(SCS_REG_STATUS, 16'h0008, "status");
    rd(SCS_REG_STATUS, 16'h0000, "status");
    wr(SCS_REG_RATE, 16'h0002, 1'b0);
    rd(SCS_REG_STATUS, 16'h0008, "status");
    rd(SCS_REG_RATE, 16'h0005, "rate");
    wr(SCS_REG_RATE, 16'h0006, 1'b1);
    rd(SCS_REG_RATE, 16'h0005, "rate");
    $display("test access done");
    for (int r = 0; r < 6; r++) begin
      wr(SCS_REG_RATE, 16'(r), 1'b1);
      #1;
      chk("rate", 16'(rate), 16'(r));
      tick_gap(per);
      tick_gap(per);
      tick_gap(per);
      chk("period", 16'(per), 16'(HZ / bps[r]));
    end
    $display("test rate done");
    ws(16'h00F7, 8'hF7);
    ws(16'h00F8, 8'hF7);
    ws(16'h0100, 8'hF7);
    ws(16'h0000, 8'h00);
    wp(16'h0001, 16'h0000);
    ws(16'h0005, 8'h05);
    wp(16'h0001, 16'h0001);
    ws(16'h00FF, 8'hFF);
    ws(16'h0000, 8'hFF);
    wp(16'h0003, 16'h0001);
    ws(16'h00F7, 8'hF7);
    wp(16'h0003, 16'h0003);
    ws(16'h00F8, 8'hF7);
    ws(16'h0000, 8'hF7);
    wp(16'h0002, 16'h0003);
    $display("test station done");
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 4; m++)
        for (int v = 0; v < 4; v++) begin
          wr(SCS_REG_SOURCE, 16'(6'h3F & ~(6'h3 << sl[k]) | (m << sl[k])),
             1'b1);
          u_scss_far.set_di(3'h7 & ~(3'(!v[1]) << k));
          u_scss_far.send(16'hFFFF & ~(16'(!v[0]) << cwb[k]));
          repeat (3) @(posedge mclk);
          #1;
          run = m == 0 ? v[1] : m == 1 ? v[0] : m == 2 ? v[1] | v[0]
              : v[1] & v[0];
          chk("request", 16'(reqs[k]), 16'(!run));
        end
    // Word without its valid bit must leave everything alone
    u_scss_far.send(16'h0000);
    repeat (3) @(posedge mclk);
    rd(SCS_REG_CWORD, 16'hFFFF, "cword");
    chk("requests", 16'(reqs), 16'h0000);
    $display("test commands done");
    complete_run();
  end
endmodule // scss_top_bench

// ===== tb/scss_top_monitor.sv
module scss_chk
  import scss_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic [3:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic        REG_LOCAL,
  input wire logic [15:0] REG_RDATA,
  input wire logic        SER_CWORD_STB,
  input wire logic        DI_COAST_N,
  input wire logic        DI_QSTOP_N,
  input wire logic        DI_DCBRAKE_N,
  input wire logic        COAST_REQ,
  input wire logic        QSTOP_REQ,
  input wire logic        DCBRAKE_REQ,
  input wire logic        BIT_TICK,
  input wire logic [7:0]  STATION_ADDR,
  input wire logic [2:0]  RATE_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  //////////////////////////////////////////////////////////////////////
  // Nothing that could move a request
  sequence s_quiet;
    $stable({DI_COAST_N, DI_QSTOP_N, DI_DCBRAKE_N})
      && !SER_CWORD_STB && !REG_WR;
  endsequence
  sequence s_bad_wr;
    REG_WR && !REG_LOCAL && REG_ADDR == SCS_REG_RATE;
  endsequence
  sequence s_stat_rd;
    REG_RD && REG_ADDR == SCS_REG_STATUS;
  endsequence
  property p_rdata_idle;
    !$past(REG_RD) |-> REG_RDATA == 16'h0000;
  endproperty
  property p_station_src;
    $changed(STATION_ADDR) |->
      $past(REG_WR && REG_LOCAL && REG_ADDR == SCS_REG_STATION);
  endproperty
  property p_rate_src;
    $changed(RATE_CODE) |->
      $past(REG_WR && REG_LOCAL && REG_ADDR == SCS_REG_RATE);
  endproperty
  property p_rate_max;
    RATE_CODE <= SCS_RATE_MAX_CODE;
  endproperty
  // Three quiet cycles cover the two-edge serial and source paths
  property p_req_hold;
    s_quiet [*3] |=> $stable({COAST_REQ, QSTOP_REQ, DCBRAKE_REQ});
  endproperty
  property p_refuse;
    s_bad_wr ##1 !REG_RD ##1 s_stat_rd |=> REG_RDATA[3];
  endproperty
  property p_clear;
    s_stat_rd ##1 !REG_WR ##1 s_stat_rd |=> !REG_RDATA[3];
  endproperty
  property p_tick_pulse;
    BIT_TICK |=> !BIT_TICK;
  endproperty
  //////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
  a_station_src: assert property (p_station_src)
    else $error("station changed without local write");
  a_rate_src: assert property (p_rate_src)
    else $error("rate changed without local write");
  a_rate_max: assert property (p_rate_max)
    else $error("rate code out of range");
  a_req_hold: assert property (p_req_hold)
    else $error("request moved with quiet inputs");
  a_refuse: assert property (p_refuse)
    else $error("serial rate write not flagged");
  a_clear: assert property (p_clear)
    else $error("refusal flag not cleared by read");
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("bit tick longer than one cycle");
endmodule // scss_chk

bind scss_top scss_chk u_scss_chk (
  .MCLK(MCLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_LOCAL(REG_LOCAL), .REG_RDATA(REG_RDATA),
  .SER_CWORD_STB(SER_CWORD_STB), .DI_COAST_N(DI_COAST_N),
  .DI_QSTOP_N(DI_QSTOP_N), .DI_DCBRAKE_N(DI_DCBRAKE_N),
  .COAST_REQ(COAST_REQ), .QSTOP_REQ(QSTOP_REQ),
  .DCBRAKE_REQ(DCBRAKE_REQ), .BIT_TICK(BIT_TICK),
  .STATION_ADDR(STATION_ADDR), .RATE_CODE(RATE_CODE));
